// ---- hw/scs_pkg.sv ----
// Notes on behaviour
// RULE_01: Trim pin falling edge resets sequencer first.
// RULE_02: Full mode: trim rise starts DAC, busy high.
// RULE_03: Full mode host must pulse conversion trigger.
// RULE_04: Full mode busy falls after DAC plus gain.
// RULE_05: Host settles offset input before trigger rise.
// RULE_06: Trigger rise starts offset phase, busy high.
// RULE_07: Busy low when offset phase time elapses.
// RULE_08: Gain-plus-offset skips DAC, shorter first phase.
// RULE_09: Gain/offset-only start on pin or write.
// RULE_10: Busy high from start until sequence ends.
// RULE_11: Host settles input before trim rise.
// RULE_12: Host stretches trim low over power-up.
// RULE_13: Host runs offset then gain, twice if large.
// RULE_14: Host repeats gain-plus-offset up to three times.
// RULE_15: Offset trims midscale/zero, gain trims full scale.
// RULE_16: Trim limited to 0.05 and 0.025 reference.
// RULE_17: Software should prefer separate gain, offset runs.
// RULE_18: Start-trim bit write starts calibration, busy.
// RULE_19: Calibration type latched from control at start.
// RULE_20: Phase lengths counted in master clock cycles.
package scs_pkg;
  localparam int unsigned CLK_HZ = 32'h017D7840;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_TRIM = 4'h8;
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_SYS_BIT = 2;
  localparam int CTRL_BIP_BIT = 3;
  localparam int CTRL_START_TRIM_BIT_BIT = 4;
  localparam int CTRL_TRIG_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [1:0] TYPE_FULL = 2'h0;
  localparam logic [1:0] TYPE_GNOF = 2'h1;
  localparam logic [1:0] TYPE_OFF = 2'h2;
  localparam logic [1:0] TYPE_GAIN = 2'h3;
  localparam int unsigned DAC_CYCLES = 32'h00030D40;
  localparam int unsigned GAIN_CYCLES = 32'h00006D60;
  localparam int unsigned OFF_CYCLES = 32'h00006D60;
  localparam logic [9:0] OFF_LIMIT = 10'h0CD;
  localparam logic [9:0] GAIN_LIMIT = 10'h066;
  typedef enum logic [2:0] {
    SCS_IDLE = 3'b000,
    SCS_DAC = 3'b001,
    SCS_GAIN = 3'b010,
    SCS_WAIT = 3'b011,
    SCS_OFF = 3'b100
  } scs_state_e;
endpackage

// ---- hw/scs_edge.sv ----
`timescale 1ns/1ps
module scs_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic prev_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 1'b1;
    end else if (ce) begin
      prev_r <= din;
    end
  end
  assign rise = ce & din & ~prev_r;
  assign fall = ce & ~din & prev_r;
endmodule

// ---- hw/scs_trim.sv ----
`timescale 1ns/1ps
module scs_trim (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic clear,
  input wire logic step,
  input wire logic up,
  input wire logic [9:0] limit,
  output logic [10:0] trim
);
  logic [10:0] trim_r;
  // Saturating trim accumulator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_r <= 11'h000;
    end else if (ce) begin
      if (clear) begin
        trim_r <= 11'h000;
      end else if (step) begin
        if (up && $signed(trim_r) < $signed({1'b0, limit})) begin // see RULE_16
          trim_r <= trim_r + 11'h001;
        end else if (!up && $signed(trim_r) > -$signed({1'b0, limit})) begin // see RULE_16
          trim_r <= trim_r - 11'h001;
        end
      end
    end
  end
  assign trim = trim_r;
endmodule

// ---- hw/scs_top.sv ----
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module scs_top
  import scs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic trim_req_b,
  input wire logic conversion_trigger,
  input wire logic cmp_high,
  output logic busy,
  output logic [10:0] offset_trim,
  output logic [10:0] gain_trim,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import scs_pkg::*;

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] r);
    addr_hit = (a[3:2] == r[3:2]);
  endfunction

  scs_state_e state_r, state_nxt;
  logic [5:0] ctrl_r, ctrl_cur;
  logic [1:0] type_r;
  logic bip_r, sys_r;
  logic [17:0] cnt_r;
  logic busy_r;
  logic trim_rise, trim_fall, trig_rise_pin;
  logic aw_got_r, w_got_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_do, sw_start, sw_trig, ctrl_wr;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic start, trig, phase_done, off_step, gain_step, off_clr, gain_clr;
  logic [10:0] off_w, gain_w;
  logic [10:0] off_out_r, gain_out_r;

  scs_edge u_trim_edge (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din(trim_req_b),
    .rise(trim_rise),
    .fall(trim_fall)
  );

  logic trig_prev_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_prev_r <= 1'b0;
    end else if (ce) begin
      trig_prev_r <= conversion_trigger;
    end
  end
  assign trig_rise_pin = ce & conversion_trigger & ~trig_prev_r;

  // AXI write channel capture, either order
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else if (ce) begin
      awready_r <= !aw_got_r && !awready_r && s_axi_awvalid;
      wready_r <= !w_got_r && !wready_r && s_axi_wvalid;
      if (awready_r && s_axi_awvalid) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_got_r <= 1'b0;
      end
      if (wready_r && s_axi_wvalid) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (ce) begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= (addr_hit(aw_addr_r, ADDR_CTRL)) ? 2'h0 : 2'h2;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign sw_start = wr_do && addr_hit(aw_addr_r, ADDR_CTRL) && w_strb_r[0]
    && w_data_r[CTRL_START_TRIM_BIT_BIT];
  assign sw_trig = wr_do && addr_hit(aw_addr_r, ADDR_CTRL) && w_strb_r[0]
    && w_data_r[CTRL_TRIG_BIT];
  // Control as seen this cycle, so a starting write uses its own type
  assign ctrl_wr = wr_do && addr_hit(aw_addr_r, ADDR_CTRL) && w_strb_r[0];
  assign ctrl_cur = ctrl_wr ? {2'b00, w_data_r[3:0]} : ctrl_r;

  // Control register; start and trigger bits self-clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET;
    end else if (ce) begin
      if (wr_do && addr_hit(aw_addr_r, ADDR_CTRL) && w_strb_r[0]) begin
        ctrl_r <= {2'b00, w_data_r[3:0]};
      end
    end
  end

  // AXI read channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
    end else if (ce) begin
      arready_r <= !arready_r && !rvalid_r && s_axi_arvalid;
      if (arready_r && s_axi_arvalid) begin
        rvalid_r <= 1'b1;
        rresp_r <= 2'h0;
        if (addr_hit(s_axi_araddr, ADDR_CTRL)) begin
          rdata_r <= {26'h0, ctrl_r};
        end else if (addr_hit(s_axi_araddr, ADDR_STAT)) begin
          rdata_r <= {26'h0, bip_r, type_r, state_r};
        end else if (addr_hit(s_axi_araddr, ADDR_TRIM)) begin
          rdata_r <= {5'h0, gain_w, 5'h0, off_w};
        end else begin
          rdata_r <= 32'h00000000;
          rresp_r <= 2'h2;
        end
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign start = trim_rise | sw_start; // see RULE_09 see RULE_18
  assign trig = trig_rise_pin | sw_trig;
  assign phase_done = (cnt_r == 18'h00001);

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SCS_IDLE: begin
        if (start) begin
          case (ctrl_cur[1:0])
            TYPE_FULL: state_nxt = SCS_DAC; // see RULE_02
            TYPE_GNOF: state_nxt = SCS_GAIN; // see RULE_08
            TYPE_GAIN: state_nxt = SCS_GAIN;
            default: state_nxt = SCS_OFF;
          endcase
        end
      end
      SCS_DAC: begin
        if (phase_done) begin
          state_nxt = SCS_GAIN;
        end
      end
      SCS_GAIN: begin
        if (phase_done) begin
          if (type_r == TYPE_GAIN) begin
            state_nxt = SCS_IDLE; // see RULE_10
          end else if (sys_r) begin
            state_nxt = SCS_WAIT; // see RULE_04
          end else begin
            state_nxt = SCS_OFF;
          end
        end
      end
      SCS_WAIT: begin
        if (trig) begin
          state_nxt = SCS_OFF; // see RULE_06
        end
      end
      SCS_OFF: begin
        if (phase_done) begin
          state_nxt = SCS_IDLE; // see RULE_07
        end
      end
      default: state_nxt = SCS_IDLE;
    endcase
    if (trim_fall) begin
      state_nxt = SCS_IDLE; // see RULE_01
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SCS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Type latched at start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      type_r <= TYPE_FULL;
      bip_r <= 1'b0;
      sys_r <= 1'b0;
    end else if (ce && state_r == SCS_IDLE && start && !trim_fall) begin
      type_r <= ctrl_cur[1:0]; // see RULE_19
      bip_r <= ctrl_cur[CTRL_BIP_BIT];
      sys_r <= ctrl_cur[CTRL_SYS_BIT]; // see RULE_19
    end
  end

  // Phase counter in master clocks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 18'h00000;
    end else if (ce) begin
      if (state_nxt != state_r) begin
        case (state_nxt)
          SCS_DAC: cnt_r <= 18'(DAC_CYCLES); // see RULE_20
          SCS_GAIN: cnt_r <= 18'(GAIN_CYCLES);
          SCS_OFF: cnt_r <= 18'(OFF_CYCLES);
          default: cnt_r <= 18'h00000;
        endcase
      end else if (cnt_r != 18'h00000) begin
        cnt_r <= cnt_r - 18'h00001;
      end
    end
  end

  // Busy low in idle and while waiting for the offset trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= (state_nxt != SCS_IDLE) && (state_nxt != SCS_WAIT); // see RULE_10
    end
  end

  // Offset trims midscale (bipolar) or zero (unipolar) via comparator
  assign off_clr = state_r == SCS_IDLE && start && ctrl_cur[1:0] != TYPE_GAIN;
  assign gain_clr = state_r == SCS_IDLE && start && ctrl_cur[1:0] != TYPE_OFF;
  assign off_step = state_r == SCS_OFF && cnt_r[7:0] == 8'h00; // see RULE_15
  assign gain_step = state_r == SCS_GAIN && cnt_r[7:0] == 8'h00; // see RULE_15

  scs_trim u_off (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(off_clr),
    .step(off_step),
    .up(cmp_high),
    .limit(OFF_LIMIT),
    .trim(off_w)
  );

  scs_trim u_gain (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .clear(gain_clr),
    .step(gain_step),
    .up(cmp_high),
    .limit(GAIN_LIMIT),
    .trim(gain_w)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      off_out_r <= 11'h000;
      gain_out_r <= 11'h000;
    end else if (ce) begin
      off_out_r <= off_w;
      gain_out_r <= gain_w;
    end
  end

  assign busy = busy_r;
  assign offset_trim = off_out_r;
  assign gain_trim = gain_out_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  property p_dac_to_gain;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_DAC && phase_done && !trim_fall) |=> state_r == SCS_GAIN;
  endproperty
  a_dac_to_gain: assert property (p_dac_to_gain) else $error("dac phase no gain"); // see RULE_04

  property p_busy_start;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_IDLE && start && !trim_fall) |=> busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised"); // see RULE_10

  property p_fall_reset;
    @(posedge clk) disable iff (!rst_b)
      trim_fall |=> state_r == SCS_IDLE && !busy;
  endproperty
  a_fall_reset: assert property (p_fall_reset) else $error("no reset on fall"); // see RULE_01

  property p_trig_off;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_WAIT && trig && !trim_fall) |=> state_r == SCS_OFF && busy;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger ignored"); // see RULE_06

  property p_wait_low;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_WAIT) |-> !busy;
  endproperty
  a_wait_low: assert property (p_wait_low) else $error("busy high in wait"); // see RULE_04

  property p_off_end;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_OFF && phase_done && !trim_fall) |=> !busy && state_r == SCS_IDLE;
  endproperty
  a_off_end: assert property (p_off_end) else $error("busy stuck"); // see RULE_07

  property p_gnof_skip;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_IDLE && start && !trim_fall && ctrl_cur[1:0] == TYPE_GNOF)
      |=> state_r == SCS_GAIN;
  endproperty
  a_gnof_skip: assert property (p_gnof_skip) else $error("dac not skipped"); // see RULE_08

  property p_sw_start;
    @(posedge clk) disable iff (!rst_b)
      (ce && state_r == SCS_IDLE && sw_start && !trim_fall) |=> busy && state_r != SCS_IDLE;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("soft start lost"); // see RULE_18
endmodule

// ---- dv/scs_host_model.sv ----
`timescale 1ns/1ps
module scs_host_model #(
  parameter int PWR_UP_CYC = 4
) (
  input wire logic clk,
  output logic trim_req_b,
  output logic conversion_trigger,
  output logic cmp_high
);
  initial begin
    trim_req_b = 1'b1;
    conversion_trigger = 1'b0;
    cmp_high = 1'b0;
  end
  // Level settles 120 ns ahead of the start edge, kept until the next call
  task automatic set_level(input logic up);
    cmp_high <= up;
    repeat (3) @(posedge clk);
  endtask
  // Low pulse stretched over power-up time
  task automatic trim_low();
    @(posedge clk);
    trim_req_b <= 1'b0;
    repeat (PWR_UP_CYC) @(posedge clk);
  endtask
  task automatic trim_high();
    trim_req_b <= 1'b1;
    @(posedge clk);
  endtask
  // Carries a system run into its offset phase
  task automatic trigger();
    conversion_trigger <= 1'b1;
    repeat (2) @(posedge clk);
    conversion_trigger <= 1'b0;
  endtask
endmodule

// ---- dv/system_calibration_sequencer_bench.sv ----
`timescale 1ns/1ps
module system_calibration_sequencer_bench;
  import scs_pkg::*;
  logic clk, rst_b, ce, trim_req_b, conversion_trigger, cmp_high, busy, busy_q, up;
  logic [10:0] offset_trim, gain_trim;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [65:0] e;
  int n_mismatch, comparisons, cyc, last_chg, d, dur, fz;
  logic [65:0] exp_r[$];
  logic [1:0] exp_b[$];
  int exp_busy[$];

  always #20 clk = ~clk;

  scs_host_model host (
    .clk(clk),
    .trim_req_b(trim_req_b),
    .conversion_trigger(conversion_trigger),
    .cmp_high(cmp_high)
  );

  scs_top dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .trim_req_b(trim_req_b),
    .conversion_trigger(conversion_trigger), .cmp_high(cmp_high), .busy(busy),
    .offset_trim(offset_trim), .gain_trim(gain_trim),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  task automatic complete_run();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v,
                    input logic [1:0] r);
    exp_r.push_back({r, m, v});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  // Bounded wait for every noted busy edge
  task automatic drain(input int n);
    int k;
    k = 0;
    while (exp_busy.size() != 0 && k < n) begin
      @(posedge clk);
      k++;
    end
    check(exp_busy.size(), 0);
    exp_busy.delete();
  endtask

  // Result watcher
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (bvalid && bready) begin
      check({30'h0, bresp}, {30'h0, (exp_b.size() != 0) ? exp_b.pop_front() : 2'h1});
    end
    if (rvalid && rready) begin
      e = (exp_r.size() != 0) ? exp_r.pop_front() : {2'h1, 64'h0};
      check({30'h0, rresp}, {30'h0, e[65:64]});
      check(rdata & e[63:32], e[31:0]);
    end
    if (!rst_b) begin
      busy_q = busy;
    end else if (busy !== busy_q) begin
      d = (exp_busy.size() != 0) ? exp_busy.pop_front() : 32'h7FFF0000;
      dur = cyc - last_chg;
      if (busy === 1'b1) begin
        check(d, 0);
      end else if (d != -1) begin
        check((d > 0 && dur >= d - 4 && dur <= d + 4) ? d : dur, d);
      end
      last_chg = cyc;
      busy_q = busy;
    end
    if (cyc == 95000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    cyc = 0;
    last_chg = 0;
    void'($urandom(32'h08cc));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL, 32'h3F, 32'h0, 2'h0);
    rd(ADDR_STAT, 32'h3F, 32'h0, 2'h0);
    rd(4'hC, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(4'hC, 32'h10, 2'h2);
    // Soft offset-only run, one phase per soft start
    up = 1'($urandom);
    host.set_level(up);
    exp_busy.push_back(0);
    exp_busy.push_back(OFF_CYCLES);
    wr(ADDR_CTRL, 32'h16, 2'h0);
    rd(ADDR_STAT, 32'h3F, 32'h14, 2'h0);
    rd(ADDR_CTRL, 32'h3F, 32'h06, 2'h0);
    drain(OFF_CYCLES + 20);
    // Gain plus offset run after the offset run, clock enable gap in its gain phase
    up = 1'($urandom);
    host.set_level(up);
    fz = 8 + $urandom_range(7);
    wr(ADDR_CTRL, 32'h0D, 2'h0);
    exp_busy.push_back(0);
    exp_busy.push_back(GAIN_CYCLES + fz);
    host.trim_low();
    host.trim_high();
    repeat (50) @(posedge clk);
    ce <= 1'b0;
    repeat (fz) @(posedge clk);
    ce <= 1'b1;
    drain(GAIN_CYCLES + 20);
    rd(ADDR_STAT, 32'h3F, 32'h2B, 2'h0);
    wr(ADDR_CTRL, 32'h03, 2'h0);
    rd(ADDR_STAT, 32'h3F, 32'h2B, 2'h0);
    rd(ADDR_TRIM, 32'h07FF0000, {5'h0, up ? 11'h066 : 11'h79A, 16'h0}, 2'h0);
    check({21'h0, gain_trim}, {21'h0, up ? 11'h066 : 11'h79A});
    host.set_level(~up);
    exp_busy.push_back(0);
    exp_busy.push_back(OFF_CYCLES);
    host.trigger();
    drain(OFF_CYCLES + 20);
    rd(ADDR_TRIM, 32'h000007FF, {21'h0, up ? 11'h793 : 11'h06D}, 2'h0);
    check({21'h0, offset_trim}, {21'h0, up ? 11'h793 : 11'h06D});
    // Full run started by pin, then cut short by a falling edge
    wr(ADDR_CTRL, 32'h04, 2'h0);
    exp_busy.push_back(0);
    host.trim_low();
    host.trim_high();
    drain(8);
    rd(ADDR_STAT, 32'h3F, 32'h01, 2'h0);
    exp_busy.push_back(-1);
    host.trim_low();
    drain(8);
    rd(ADDR_STAT, 32'h07, 32'h00, 2'h0);
    // Gain-only run started by pin
    wr(ADDR_CTRL, 32'h07, 2'h0);
    exp_busy.push_back(0);
    host.trim_high();
    drain(8);
    rd(ADDR_STAT, 32'h3F, 32'h1A, 2'h0);
    exp_busy.push_back(-1);
    host.trim_low();
    drain(8);
    complete_run();
  end
endmodule
